//--- pkg/csr_pkg.sv
package csr_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_CH_POWERDOWN = 8'h11;
  localparam logic [7:0] OFS_PLL1_RATIO = 8'h18;
  localparam logic [7:0] OFS_PLL2_NUM_HIGH = 8'h19;
  localparam logic [7:0] OFS_PLL2_NUM_LOW_DEN_HIGH = 8'h1A;
  localparam logic [7:0] OFS_PLL2_DEN_LOW = 8'h1B;
  localparam logic [7:0] OFS_PLL2_RATIO = 8'h1C;
  localparam logic [7:0] OFS_PLL2_MOD_CTRL = 8'h1D;
  localparam logic [7:0] OFS_RELOCK = 8'h1F;
  localparam logic [7:0] OFS_CH0_DIV = 8'h22;
  localparam logic [7:0] OFS_CH1_DIV = 8'h23;
  localparam logic [7:0] OFS_PLL1_SYNC = 8'h24;
  localparam logic [7:0] OFS_CH2_DIV = 8'h25;
  localparam logic [7:0] OFS_CH3_DIV = 8'h26;
  localparam logic [7:0] OFS_RAMP_INC = 8'h2A;
  localparam logic [7:0] OFS_RAMP_STEP_HIGH = 8'h2B;
  localparam logic [7:0] OFS_RAMP_STEP_LOW_RATE = 8'h2C;
  localparam logic [7:0] OFS_SERIAL_ENABLE = 8'h40;
  // ==========================================
  // field positions
  localparam int BIT_CH0_PD = 0;
  localparam int BIT_CH1_PD = 1;
  localparam int BIT_BLEED = 2;
  localparam int BIT_SDM_OFF = 4;
  localparam int BIT_RELOCK = 0;
  localparam int BIT_ALIGN = 0;
  localparam int BIT_SERIAL_EN = 1;
  localparam int BIT_STEP_LSB = 7;
  // ==========================================
  // sizes and reset values
  localparam int MAP_DEPTH = 128;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
  // ==========================================
  // decoded configuration
  typedef struct packed {
    logic [5:0] pll1_feedback_ratio;
    logic [5:0] pll2_integer_ratio;
    logic [11:0] pll2_numerator;
    logic [11:0] divider_denominator;
    logic sigma_delta_off;
    logic [3:0][2:0] vco_divider;
    logic [3:0][4:0] output_divider;
    logic ch0_powerdown;
    logic ch1_powerdown;
    logic bleed;
    logic align_outputs_a;
    logic relock_trigger;
    logic serial_config_enable;
    logic [8:0] half_ramp_step_count;
    logic [7:0] ramp_increment;
    logic [6:0] ramp_rate_divider;
  } csr_cfg_type;
endpackage

//--- core/csr_top.sv
`timescale 1ns/10ps
`default_nettype none
module csr_top #(
  parameter logic [6:0] DEV_ADDR = csr_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SPREAD_IN,
  output csr_pkg::csr_cfg_type CFG,
  output logic [11:0] RAMP_NUMERATOR,
  output logic RAMP_ACTIVE
);
  import csr_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_SUB = 4'h2,
    ST_SUB_ACK = 4'h6,
    ST_WR = 4'h7,
    ST_WR_ACK = 4'h5,
    ST_RD = 4'h4,
    ST_RD_ACK = 4'hC
  } csr_state_type;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      OFS_CH_POWERDOWN, OFS_PLL1_RATIO, OFS_PLL2_NUM_HIGH, OFS_PLL2_NUM_LOW_DEN_HIGH,
      OFS_PLL2_DEN_LOW, OFS_PLL2_RATIO, OFS_PLL2_MOD_CTRL, OFS_RELOCK, OFS_CH0_DIV,
      OFS_CH1_DIV, OFS_PLL1_SYNC, OFS_CH2_DIV, OFS_CH3_DIV, OFS_RAMP_INC,
      OFS_RAMP_STEP_HIGH, OFS_RAMP_STEP_LOW_RATE, OFS_SERIAL_ENABLE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] map_rd(input logic [7:0] a, input logic [MAP_DEPTH-1:0][7:0] m);
    map_rd = a[7] ? 8'h00 : m[a[6:0]];
  endfunction

  // ==========================================
  // pin synchronisers
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] ss_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic ss_prev_q;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      ss_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      ss_prev_q <= 1'b0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], SCL_IN};
      sda_sync_q <= {sda_sync_q[0], SDA_IN};
      ss_sync_q <= {ss_sync_q[0], SPREAD_IN};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
      ss_prev_q <= ss_sync_q[1];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl = scl_sync_q[1];
  assign sda = sda_sync_q[1];
  assign scl_rise = scl & ~scl_prev_q;
  assign scl_fall = ~scl & scl_prev_q;
  assign start_seen = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop_seen = scl & scl_prev_q & ~sda_prev_q & sda;

  // ==========================================
  // serial slave
  csr_state_type st_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic got_q;
  logic rw_q;
  logic nack_q;
  logic [7:0] ptr_q;
  logic wr_q;
  logic [MAP_DEPTH-1:0][7:0] mem_q;
  logic [7:0] rd_byte;
  assign rd_byte = map_rd(ptr_q, mem_q);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      got_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
      wr_q <= 1'b0;
      SDA_OE <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (start_seen) begin
        st_q <= ST_ADDR;
        cnt_q <= 3'h0;
        got_q <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (stop_seen) begin
        st_q <= ST_IDLE;
        SDA_OE <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == ST_ADDR || st_q == ST_SUB || st_q == ST_WR || st_q == ST_RD) begin
          if (st_q != ST_RD) begin
            sh_q <= {sh_q[6:0], sda};
          end
          cnt_q <= cnt_q + 3'h1;
          got_q <= (cnt_q == 3'h7);
        end
        if (st_q == ST_RD_ACK) begin
          nack_q <= sda;
        end
      end else if (scl_fall) begin
        unique case (st_q)
          ST_IDLE: begin
          end
          ST_ADDR: begin
            if (got_q) begin
              got_q <= 1'b0;
              rw_q <= sh_q[0];
              // a foreign address leaves the bus alone until the next start
              if (sh_q[7:1] == DEV_ADDR) begin
                st_q <= ST_ADDR_ACK;
                SDA_OE <= 1'b1;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            cnt_q <= 3'h0;
            if (rw_q) begin
              st_q <= ST_RD;
              sh_q <= rd_byte;
              SDA_OE <= ~rd_byte[7];
            end else begin
              st_q <= ST_SUB;
              SDA_OE <= 1'b0;
            end
          end
          ST_SUB: begin
            if (got_q) begin
              got_q <= 1'b0;
              ptr_q <= sh_q;
              st_q <= ST_SUB_ACK;
              SDA_OE <= 1'b1;
            end
          end
          ST_SUB_ACK: begin
            st_q <= ST_WR;
            cnt_q <= 3'h0;
            SDA_OE <= 1'b0;
          end
          ST_WR: begin
            if (got_q) begin
              got_q <= 1'b0;
              wr_q <= 1'b1;
              st_q <= ST_WR_ACK;
              SDA_OE <= 1'b1;
            end
          end
          ST_WR_ACK: begin
            ptr_q <= ptr_q + 8'h01;
            st_q <= ST_WR;
            cnt_q <= 3'h0;
            SDA_OE <= 1'b0;
          end
          ST_RD: begin
            if (got_q) begin
              got_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              st_q <= ST_RD_ACK;
              SDA_OE <= 1'b0;
            end else begin
              SDA_OE <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
          ST_RD_ACK: begin
            cnt_q <= 3'h0;
            // a master nack ends the read; the bus stays released until the next start
            if (nack_q) begin
              st_q <= ST_IDLE;
              SDA_OE <= 1'b0;
            end else begin
              st_q <= ST_RD;
              sh_q <= rd_byte;
              SDA_OE <= ~rd_byte[7];
            end
          end
          default: begin
            st_q <= ST_IDLE;
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge CLK) begin
    SDA_OUT <= 1'b0;
  end

  // ==========================================
  // register array
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < MAP_DEPTH; i++) begin
        mem_q[i] <= REG_RESET;
      end
    end else if (wr_q && is_mapped(ptr_q)) begin
      // unmapped sub-addresses swallow the byte but still ack
      mem_q[ptr_q[6:0]] <= sh_q;
    end
  end

  // ==========================================
  // field decode, straight from the array flops
  always_comb begin
    CFG.pll1_feedback_ratio = mem_q[OFS_PLL1_RATIO[6:0]][5:0];
    CFG.pll2_integer_ratio = mem_q[OFS_PLL2_RATIO[6:0]][5:0];
    CFG.pll2_numerator = {mem_q[OFS_PLL2_NUM_HIGH[6:0]], mem_q[OFS_PLL2_NUM_LOW_DEN_HIGH[6:0]][7:4]};
    CFG.divider_denominator = {mem_q[OFS_PLL2_NUM_LOW_DEN_HIGH[6:0]][3:0], mem_q[OFS_PLL2_DEN_LOW[6:0]]};
    CFG.sigma_delta_off = mem_q[OFS_PLL2_MOD_CTRL[6:0]][BIT_SDM_OFF];
    CFG.vco_divider[0] = mem_q[OFS_CH0_DIV[6:0]][7:5];
    CFG.vco_divider[1] = mem_q[OFS_CH1_DIV[6:0]][7:5];
    CFG.vco_divider[2] = mem_q[OFS_CH2_DIV[6:0]][7:5];
    CFG.vco_divider[3] = mem_q[OFS_CH3_DIV[6:0]][7:5];
    CFG.output_divider[0] = mem_q[OFS_CH0_DIV[6:0]][4:0];
    CFG.output_divider[1] = mem_q[OFS_CH1_DIV[6:0]][4:0];
    CFG.output_divider[2] = mem_q[OFS_CH2_DIV[6:0]][4:0];
    CFG.output_divider[3] = mem_q[OFS_CH3_DIV[6:0]][4:0];
    CFG.ch0_powerdown = mem_q[OFS_CH_POWERDOWN[6:0]][BIT_CH0_PD];
    CFG.ch1_powerdown = mem_q[OFS_CH_POWERDOWN[6:0]][BIT_CH1_PD];
    CFG.bleed = mem_q[OFS_CH_POWERDOWN[6:0]][BIT_BLEED];
    CFG.align_outputs_a = mem_q[OFS_PLL1_SYNC[6:0]][BIT_ALIGN];
    CFG.relock_trigger = mem_q[OFS_RELOCK[6:0]][BIT_RELOCK];
    CFG.serial_config_enable = mem_q[OFS_SERIAL_ENABLE[6:0]][BIT_SERIAL_EN];
    CFG.half_ramp_step_count = {mem_q[OFS_RAMP_STEP_HIGH[6:0]],
                                mem_q[OFS_RAMP_STEP_LOW_RATE[6:0]][BIT_STEP_LSB]};
    CFG.ramp_increment = mem_q[OFS_RAMP_INC[6:0]];
    CFG.ramp_rate_divider = mem_q[OFS_RAMP_STEP_LOW_RATE[6:0]][6:0];
  end

  // ==========================================
  // spread ramp generator
  // settings are captured only on the rising spread input, so edits need a toggle
  logic [8:0] n_steps_q;
  logic [7:0] inc_q;
  logic [6:0] div_q;
  logic [6:0] div_cnt_q;
  logic [8:0] step_q;
  logic down_q;
  logic signed [17:0] ofs_q;
  logic tick;
  assign tick = RAMP_ACTIVE && (div_cnt_q == div_q - 7'h01);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      n_steps_q <= 9'h000;
      inc_q <= 8'h00;
      div_q <= 7'h00;
      div_cnt_q <= 7'h00;
      step_q <= 9'h000;
      down_q <= 1'b1;
      ofs_q <= 18'sh00000;
      RAMP_ACTIVE <= 1'b0;
    end else if (ss_sync_q[1] && !ss_prev_q) begin
      n_steps_q <= CFG.half_ramp_step_count;
      inc_q <= CFG.ramp_increment;
      div_q <= CFG.ramp_rate_divider;
      div_cnt_q <= 7'h00;
      step_q <= 9'h000;
      down_q <= 1'b1;
      ofs_q <= 18'sh00000;
      RAMP_ACTIVE <= 1'b1;
    end else if (!ss_sync_q[1]) begin
      RAMP_ACTIVE <= 1'b0;
      ofs_q <= 18'sh00000;
    end else begin
      div_cnt_q <= tick ? 7'h00 : div_cnt_q + 7'h01;
      if (tick) begin
        // increment is negative, so the down leg adds it and the up leg removes it
        ofs_q <= down_q ? ofs_q + 18'(signed'(inc_q)) : ofs_q - 18'(signed'(inc_q));
        if (step_q + 9'h001 >= n_steps_q) begin
          step_q <= 9'h000;
          down_q <= ~down_q;
        end else begin
          step_q <= step_q + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      RAMP_NUMERATOR <= 12'h000;
    end else begin
      RAMP_NUMERATOR <= CFG.pll2_numerator + ofs_q[11:0];
    end
  end
endmodule
`default_nettype wire

//--- tb/csr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module csr_properties
  import csr_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic SPREAD_IN,
  input wire csr_cfg_type CFG,
  input wire logic [11:0] RAMP_NUMERATOR,
  input wire logic RAMP_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // ==========================================
  // step spacing; first step skipped, its phase is free
  logic [7:0] gap_q;
  logic seen_q;
  logic [11:0] last_q;
  logic [11:0] inc_x;
  assign inc_x = {{4{CFG.ramp_increment[7]}}, CFG.ramp_increment};
  always_ff @(posedge CLK) begin
    last_q <= RAMP_NUMERATOR;
  end
  always_ff @(posedge CLK) begin
    if (SRST || !RAMP_ACTIVE || RAMP_NUMERATOR != last_q) gap_q <= 8'h00;
    else gap_q <= gap_q + 8'h01;
  end
  always_ff @(posedge CLK) begin
    if (SRST || !RAMP_ACTIVE) seen_q <= 1'b0;
    else if (RAMP_NUMERATOR != last_q) seen_q <= 1'b1;
  end
  // ==========================================
  // checks
  a_sda_pull_low: assert property (SDA_OE |-> SDA_OUT == 1'b0) else $error("pin driven high");
  a_ack_scl_low: assert property ($rose(SDA_OE) |-> !SCL_IN) else $error("pin taken with clock high");
  a_oe_hold_high: assert property (SCL_IN [*6] |-> $stable(SDA_OE)) else $error("pin moved in clock high");
  a_idle_num: assert property ((!RAMP_ACTIVE && $stable(CFG.pll2_numerator)) [*3]
    |-> RAMP_NUMERATOR == CFG.pll2_numerator) else $error("idle numerator wrong");
  a_ramp_start: assert property ($rose(SPREAD_IN) ##1 SPREAD_IN [*5] |-> RAMP_ACTIVE)
    else $error("ramp did not start");
  a_ramp_stop: assert property (!SPREAD_IN [*5] |-> !RAMP_ACTIVE) else $error("ramp did not stop");
  a_step_size: assert property (RAMP_ACTIVE && $past(RAMP_ACTIVE) && $changed(RAMP_NUMERATOR)
    |-> (12'(RAMP_NUMERATOR - $past(RAMP_NUMERATOR)) == inc_x)
    || (12'(RAMP_NUMERATOR - $past(RAMP_NUMERATOR)) == 12'(12'h000 - inc_x)))
    else $error("ramp step wrong");
  a_step_rate: assert property (RAMP_ACTIVE && seen_q && RAMP_NUMERATOR != last_q
    |-> gap_q == {1'b0, CFG.ramp_rate_divider} - 8'h01) else $error("ramp rate wrong");
endmodule
`default_nettype wire

//--- tb/csr_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module csr_master_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  localparam int HALF = 8;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // ==========================================
  // bit engine; data moves two clocks after the fall, never with it
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge clk);
    sda_rel = b;
    repeat (HALF) @(negedge clk);
    scl = 1'b1;
    repeat (HALF) @(negedge clk);
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic start_c();
    // data released while the clock is low, then pulled low with the clock high
    repeat (2) @(negedge clk);
    sda_rel = 1'b1;
    repeat (HALF) @(negedge clk);
    scl = 1'b1;
    repeat (HALF) @(negedge clk);
    sda_rel = 1'b0;
    repeat (HALF) @(negedge clk);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    repeat (2) @(negedge clk);
    sda_rel = 1'b0;
    repeat (HALF) @(negedge clk);
    scl = 1'b1;
    repeat (HALF) @(negedge clk);
    sda_rel = 1'b1;
    repeat (HALF) @(negedge clk);
  endtask
  task automatic tx(input logic [7:0] b, inout int nk);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nk++;
  endtask
  // ==========================================
  // transfers
  task automatic xw(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d[$], output int nk);
    nk = 0;
    start_c();
    tx({a, 1'b0}, nk);
    tx(s, nk);
    foreach (d[i]) tx(d[i], nk);
    stop_c();
  endtask
  task automatic xr(input logic [7:0] s, input int n, output logic [7:0] q[$], output int nk);
    logic [7:0] v;
    logic r;
    nk = 0;
    q = {};
    start_c();
    tx({ADDR, 1'b0}, nk);
    tx(s, nk);
    start_c();
    tx({ADDR, 1'b1}, nk);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(k == n - 1, r);
      q.push_back(v);
    end
    stop_c();
  endtask
endmodule
`default_nettype wire

//--- tb/test_csr_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_csr_top;
  import csr_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic spread = 1'b0;
  logic scl, sda_rel, sda_oe, sda_out, ract;
  wire logic sda_line = sda_rel & !(sda_oe & !sda_out);
  csr_cfg_type cfg;
  logic [11:0] rnum;
  logic [7:0] q[$];
  int err_total = 0;
  int cmp_count = 0;
  int nk, gap;
  // sub, data, field, expected; writes keep unused bits zero, except 8'hD0 to sub 8'h1D
  logic [31:0] rows [17] = '{
    {8'h18, 8'h2B, 4'h0, 12'h02B},
    {8'h1C, 8'h3F, 4'h1, 12'h03F},
    {8'h19, 8'h0C, 4'h2, 12'h0C0},
    {8'h1A, 8'h62, 4'h2, 12'h0C6},
    {8'h1B, 8'h71, 4'h3, 12'h271},
    {8'h22, 8'hA5, 4'h4, 12'h0A5},
    {8'h23, 8'h3C, 4'h5, 12'h03C},
    {8'h25, 8'h84, 4'h6, 12'h084},
    {8'h26, 8'h90, 4'h7, 12'h090},
    {8'h2B, 8'h16, 4'h8, 12'h02C},
    {8'h2C, 8'h89, 4'h8, 12'h02D},
    {8'h2C, 8'h89, 4'h9, 12'h009},
    {8'h2A, 8'hF9, 4'hA, 12'h0F9},
    {8'h11, 8'h05, 4'hB, 12'h005},
    {8'h1D, 8'hD0, 4'hC, 12'h004},
    {8'h1F, 8'h01, 4'hC, 12'h006},
    {8'h40, 8'h02, 4'hC, 12'h007}};
  always #12.5 clk = ~clk;
  csr_top csr_top_inst (.CLK(clk), .SRST(srst), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .SPREAD_IN(spread), .CFG(cfg), .RAMP_NUMERATOR(rnum), .RAMP_ACTIVE(ract));
  csr_master_model #(.ADDR(DEV_ADDR_DEFAULT)) csr_master_model_inst (.clk(clk), .sda_line(sda_line),
    .scl(scl), .sda_rel(sda_rel));
  // ==========================================
  // helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] fld(input int s);
    case (s)
      0: return 12'(cfg.pll1_feedback_ratio);
      1: return 12'(cfg.pll2_integer_ratio);
      2: return cfg.pll2_numerator;
      3: return cfg.divider_denominator;
      4, 5, 6, 7: return {4'h0, cfg.vco_divider[s-4], cfg.output_divider[s-4]};
      8: return 12'(cfg.half_ramp_step_count);
      9: return 12'(cfg.ramp_rate_divider);
      10: return 12'(cfg.ramp_increment);
      12: return {9'h000, cfg.sigma_delta_off, cfg.relock_trigger, cfg.serial_config_enable};
      default: return {9'h000, cfg.bleed, cfg.ch1_powerdown, cfg.ch0_powerdown};
    endcase
  endfunction
  task automatic wait_chg(output int n);
    logic [11:0] v;
    v = rnum;
    n = 0;
    while (rnum === v && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d of %0d compares", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 17; i++) begin
      csr_master_model_inst.xw(DEV_ADDR_DEFAULT, rows[i][31:24], {rows[i][23:16]}, nk);
      chk(12'(nk), 12'h000);
      chk(fld(rows[i][15:12]), rows[i][11:0]);
    end
    $display("table done");
    csr_master_model_inst.xw(DEV_ADDR_DEFAULT, 8'h22, {8'h11, 8'h22, 8'h01, 8'h44}, nk);
    chk(12'(nk), 12'h000);
    chk(fld(4), 12'h011);
    chk(fld(5), 12'h022);
    chk(fld(6), 12'h044);
    chk({11'h000, cfg.align_outputs_a}, 12'h001);
    csr_master_model_inst.xr(8'h22, 4, q, nk);
    chk(12'(nk), 12'h000);
    chk({q[0][3:0], q[1]}, 12'h122);
    chk({q[2][3:0], q[3]}, 12'h144);
    csr_master_model_inst.xw(7'h2B, 8'h18, {8'h00}, nk);
    chk(12'(nk), 12'h003);
    chk(fld(0), 12'h02B);
    $display("burst and foreign address done");
    spread = 1'b1;
    wait_chg(gap);
    chk(rnum, 12'h0BF);
    wait_chg(gap);
    chk(12'(gap), 12'h009);
    repeat (43) wait_chg(gap);
    chk(rnum, 12'(12'h0C6 - 12'd315));
    wait_chg(gap);
    chk(rnum, 12'(12'h0C6 - 12'd308));
    spread = 1'b0;
    repeat (8) @(negedge clk);
    chk({ract, rnum[10:0]}, 12'h0C6);
    $display("ramp done");
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk({9'h000, cfg === '0, ract, sda_oe}, 12'h004);
    chk(rnum, 12'h000);
    $display("reset done");
    conclude();
  end
  initial begin
    repeat (40000) @(negedge clk);
    err_total++;
    conclude();
  end
endmodule
bind csr_top csr_properties csr_properties_inst (.CLK(CLK), .SRST(SRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SPREAD_IN(SPREAD_IN), .CFG(CFG), .RAMP_NUMERATOR(RAMP_NUMERATOR),
  .RAMP_ACTIVE(RAMP_ACTIVE));
`default_nettype wire
